// file: hdl/scm_pkg.sv
// Constants, types and register map of the system clock and mode control
//
// Contract
// - low_osc_select 0 sources sub_clk from slow RC, 1 from crystal.
// - Halt with both keep bits 0 enters SLEEP; CPU, fast, sub and system clocks stop.
// - slow_rc_clk always runs, also in SLEEP, for the watchdog.
// - Halt with fast keep 0, slow keep 1: sub_clk on; sysclk only if 111.
// - Halt with both keep bits 1: fast, sub and system clock all run.
// - Halt with fast keep 1, slow keep 0: sub_clk off; sysclk if not 111.
// - Running from sub_clk, fast_clk follows its enable bit.
// - Running fast with CPU active, all three clocks run.
// - Clock switch completes within 4 system periods plus source alignment.
// - hsrc_freq_select 00/01/10/11 gives 8/12/16/8 MHz.
// - New fast RC frequency applies only once the stable flag is 1.
// - Enabling fast RC clears its stable flag, which sets when stable.
// - hsrc_enable runs or stops the fast RC while running from sub_clk; resets to 1.
// - xtal_drive_mode 00 low power, 01 quick start, 1x high ESR.
// - xtal_drive_mode writes ignored while crystal is the system clock.
// - Enabling crystal clears its stable flag, which sets when stable.
// - fast_osc_halt_keep decides if fast oscillator runs during halt.
// - slow_osc_halt_keep decides if sub_clk runs during halt.
package scm_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_SYSCLK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FAST_RC_CTRL = 4'h4;
  localparam logic [3:0] ADDR_XTAL_CTRL = 4'h8;
  localparam logic [7:0] SYSCLK_CTRL_RST = 8'h00;
  localparam logic [7:0] FAST_RC_CTRL_RST = 8'h01;
  localparam logic [7:0] XTAL_CTRL_RST = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SEL_LSB = 5;
  localparam int LOW_OSC_BIT = 2;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam int CODE_LSB = 2;
  localparam int FLAG_BIT = 1;
  localparam int ENABLE_BIT = 0;

  // ****************************************
  // Codes and timing
  // ****************************************
  localparam logic [2:0] SEL_SUB = 3'h7;
  localparam logic [2:0] SWITCH_SYS_PERIODS = 3'h4;
  localparam logic [1:0] FREQ_8MHZ = 2'h0;
  localparam logic [1:0] FREQ_12MHZ = 2'h1;
  localparam logic [1:0] FREQ_16MHZ = 2'h2;
  localparam logic [1:0] DRIVE_LOW_POWER = 2'h0;
  localparam logic [1:0] DRIVE_QUICK_START = 2'h1;
  localparam logic [1:0] DRIVE_HIGH_ESR = 2'h2;

  typedef enum logic [2:0] {
    MODE_FAST, MODE_SLOW, MODE_SLEEP,
    MODE_IDLE_SUB_ONLY, MODE_IDLE_BOTH_CLOCKS, MODE_IDLE_FAST_ONLY
  } scm_mode_t;

  typedef struct packed {
    logic fast_tick;
    logic slow_rc_tick;
    logic xtal_tick;
  } scm_osc_in_t;

  typedef struct packed {
    logic hsrc_run;
    logic [1:0] hsrc_freq;
    logic xtal_run;
    logic [1:0] xtal_drive;
    logic fast_clk_on;
    logic sub_clk_on;
    logic slow_rc_on;
    logic sys_tick;
    logic cpu_run;
  } scm_clk_out_t;

endpackage : scm_pkg

// file: hdl/scm_top.sv
// System clock selection, oscillator control and halt modes
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
module scm_top
  import scm_pkg::*;
#(
  parameter int HSRC_STAB_TICKS = 64,
  parameter int XTAL_STAB_TICKS = 256
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire scm_osc_in_t osc_in,
  output scm_clk_out_t clk_out,
  output scm_mode_t op_mode
);

  // ****************************************
  // Registers
  // ****************************************
  logic [2:0] sel_r, sel_nxt;
  logic low_osc_r, low_osc_nxt;
  logic fast_keep_r, fast_keep_nxt;
  logic slow_keep_r, slow_keep_nxt;
  logic [1:0] hfreq_r, hfreq_nxt;
  logic hflag_r, hflag_nxt;
  logic hen_r, hen_nxt;
  logic [1:0] drive_r, drive_nxt;
  logic xflag_r, xflag_nxt;
  logic xen_r, xen_nxt;
  logic [15:0] hcnt_r, hcnt_nxt;
  logic [15:0] xcnt_r, xcnt_nxt;
  logic [1:0] freq_out_r, freq_out_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r, wait_nxt;
  logic [2:0] act_sel_r, act_sel_nxt;
  logic act_low_r, act_low_nxt;
  logic [2:0] sw_cnt_r, sw_cnt_nxt;
  logic [5:0] div_r, div_nxt;
  scm_mode_t mode_r, mode_nxt;
  scm_clk_out_t out_r, out_nxt;

  logic wr_en;
  logic wr_sys;
  logic wr_fast;
  logic wr_xtal;
  logic halted;
  logic halt_nxt;
  logic fast_on;
  logic sub_on;
  logic xtal_on;
  logic sys_on;
  logic fast_t;
  logic div_t;
  logic sub_cur_t;
  logic sub_tar_t;
  logic cur_t;
  logic tar_t;
  logic [5:0] mask;
  logic pending;

  // ****************************************
  // Combinational next state
  // ****************************************
  always_comb begin
    wr_en = avs_write && !wait_r;
    wr_sys = wr_en && (avs_address == ADDR_SYSCLK_CTRL);
    wr_fast = wr_en && (avs_address == ADDR_FAST_RC_CTRL);
    wr_xtal = wr_en && (avs_address == ADDR_XTAL_CTRL);
    halted = (mode_r != MODE_FAST) && (mode_r != MODE_SLOW);

    // Operating mode
    mode_nxt = mode_r;
    if (!halted) begin
      mode_nxt = (act_sel_r == SEL_SUB) ? MODE_SLOW : MODE_FAST;
      if (halt_req) begin
        unique case ({fast_keep_r, slow_keep_r})
          2'b00: mode_nxt = MODE_SLEEP;
          2'b01: mode_nxt = MODE_IDLE_SUB_ONLY;
          2'b11: mode_nxt = MODE_IDLE_BOTH_CLOCKS;
          2'b10: mode_nxt = MODE_IDLE_FAST_ONLY;
        endcase
      end
    end else if (wake_req) begin
      mode_nxt = (act_sel_r == SEL_SUB) ? MODE_SLOW : MODE_FAST;
    end
    halt_nxt = (mode_nxt != MODE_FAST) && (mode_nxt != MODE_SLOW);

    // Oscillator run control, same edge as mode
    fast_on = halt_nxt ? fast_keep_r
                       : (hen_r || (act_sel_r != SEL_SUB));
    sub_on = !halt_nxt || slow_keep_r;
    xtal_on = xen_r;

    // Source ticks
    fast_t = osc_in.fast_tick && out_r.fast_clk_on;
    mask = 6'((7'h01 << act_sel_r) - 7'h01);
    div_t = fast_t && ((div_r & mask) == mask);
    sub_cur_t = out_r.sub_clk_on && (act_low_r ?
                (osc_in.xtal_tick && out_r.xtal_run)
                : osc_in.slow_rc_tick);
    sub_tar_t = out_r.sub_clk_on && (low_osc_r ?
                (osc_in.xtal_tick && out_r.xtal_run)
                : osc_in.slow_rc_tick);
    cur_t = (act_sel_r == SEL_SUB) ? sub_cur_t : div_t;
    tar_t = (sel_r == SEL_SUB) ? sub_tar_t : fast_t;

    // System clock gating per mode
    unique case (mode_nxt)
      MODE_FAST, MODE_SLOW: sys_on = 1'b1;
      MODE_SLEEP: sys_on = 1'b0;
      MODE_IDLE_SUB_ONLY: sys_on = (act_sel_r == SEL_SUB);
      MODE_IDLE_BOTH_CLOCKS: sys_on = 1'b1;
      MODE_IDLE_FAST_ONLY: sys_on = (act_sel_r != SEL_SUB);
      default: sys_on = 1'b0;
    endcase

    // Register writes
    sel_nxt = sel_r;
    low_osc_nxt = low_osc_r;
    fast_keep_nxt = fast_keep_r;
    slow_keep_nxt = slow_keep_r;
    hfreq_nxt = hfreq_r;
    hen_nxt = hen_r;
    drive_nxt = drive_r;
    xen_nxt = xen_r;
    if (wr_sys) begin
      sel_nxt = avs_writedata[SEL_LSB +: 3];
      low_osc_nxt = avs_writedata[LOW_OSC_BIT];
      fast_keep_nxt = avs_writedata[FAST_KEEP_BIT];
      slow_keep_nxt = avs_writedata[SLOW_KEEP_BIT];
    end
    if (wr_fast) begin
      hfreq_nxt = avs_writedata[CODE_LSB +: 2];
      hen_nxt = avs_writedata[ENABLE_BIT];
    end
    if (wr_xtal) begin
      if (!((sel_r == SEL_SUB) && low_osc_r)) begin
        drive_nxt = avs_writedata[CODE_LSB +: 2];
      end
      xen_nxt = avs_writedata[ENABLE_BIT];
    end

    // Fast RC stable flag and applied frequency
    hflag_nxt = hflag_r;
    hcnt_nxt = hcnt_r;
    freq_out_nxt = freq_out_r;
    if (!out_r.hsrc_run) begin
      hflag_nxt = 1'b0;
      hcnt_nxt = '0;
    end else if (wr_fast && ((avs_writedata[ENABLE_BIT] && !hen_r)
                 || (avs_writedata[CODE_LSB +: 2] != hfreq_r))) begin
      hflag_nxt = 1'b0;
      hcnt_nxt = '0;
    end else if (!hflag_r && osc_in.fast_tick) begin
      if (hcnt_r == 16'(HSRC_STAB_TICKS - 1)) begin
        hflag_nxt = 1'b1;
        freq_out_nxt = (hfreq_r == FREQ_12MHZ) ? FREQ_12MHZ
                     : (hfreq_r == FREQ_16MHZ) ? FREQ_16MHZ
                     : FREQ_8MHZ;
      end else begin
        hcnt_nxt = hcnt_r + 16'h0001;
      end
    end

    // Crystal stable flag
    xflag_nxt = xflag_r;
    xcnt_nxt = xcnt_r;
    if (!out_r.xtal_run) begin
      xflag_nxt = 1'b0;
      xcnt_nxt = '0;
    end else if (wr_xtal && avs_writedata[ENABLE_BIT] && !xen_r) begin
      xflag_nxt = 1'b0;
      xcnt_nxt = '0;
    end else if (!xflag_r && osc_in.xtal_tick) begin
      if (xcnt_r == 16'(XTAL_STAB_TICKS - 1)) begin
        xflag_nxt = 1'b1;
      end else begin
        xcnt_nxt = xcnt_r + 16'h0001;
      end
    end

    // Clock switch sequencing
    pending = (sel_r != act_sel_r) || (low_osc_r != act_low_r);
    act_sel_nxt = act_sel_r;
    act_low_nxt = act_low_r;
    sw_cnt_nxt = '0;
    if (pending) begin
      sw_cnt_nxt = sw_cnt_r;
      if (sw_cnt_r < SWITCH_SYS_PERIODS) begin
        if (cur_t) begin
          sw_cnt_nxt = sw_cnt_r + 3'h1;
        end
      end else if (tar_t) begin
        act_sel_nxt = sel_r;
        act_low_nxt = low_osc_r;
        sw_cnt_nxt = '0;
      end
    end
    div_nxt = fast_t ? div_r + 6'h01 : div_r;

    // Outputs
    out_nxt.hsrc_run = fast_on;
    out_nxt.hsrc_freq = freq_out_r;
    out_nxt.xtal_run = xtal_on;
    out_nxt.xtal_drive = drive_r;
    out_nxt.fast_clk_on = fast_on;
    out_nxt.sub_clk_on = sub_on;
    out_nxt.slow_rc_on = 1'b1;
    out_nxt.sys_tick = cur_t && sys_on;
    out_nxt.cpu_run = (mode_nxt == MODE_FAST) || (mode_nxt == MODE_SLOW);

    // Bus answer
    wait_nxt = !((avs_read || avs_write) && wait_r);
    rdata_nxt = '0;
    unique case (avs_address)
      ADDR_SYSCLK_CTRL: rdata_nxt[7:0] = {sel_r, 2'b00, low_osc_r,
                                          fast_keep_r, slow_keep_r};
      ADDR_FAST_RC_CTRL: rdata_nxt[7:0] = {4'h0, hfreq_r, hflag_r, hen_r};
      ADDR_XTAL_CTRL: rdata_nxt[7:0] = {4'h0, drive_r, xflag_r, xen_r};
      default: rdata_nxt = '0;
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_r <= SYSCLK_CTRL_RST[SEL_LSB +: 3];
      low_osc_r <= SYSCLK_CTRL_RST[LOW_OSC_BIT];
      fast_keep_r <= SYSCLK_CTRL_RST[FAST_KEEP_BIT];
      slow_keep_r <= SYSCLK_CTRL_RST[SLOW_KEEP_BIT];
      hfreq_r <= FAST_RC_CTRL_RST[CODE_LSB +: 2];
      hflag_r <= FAST_RC_CTRL_RST[FLAG_BIT];
      hen_r <= FAST_RC_CTRL_RST[ENABLE_BIT];
      drive_r <= XTAL_CTRL_RST[CODE_LSB +: 2];
      xflag_r <= XTAL_CTRL_RST[FLAG_BIT];
      xen_r <= XTAL_CTRL_RST[ENABLE_BIT];
      hcnt_r <= '0;
      xcnt_r <= '0;
      freq_out_r <= FREQ_8MHZ;
      rdata_r <= '0;
      wait_r <= 1'b1;
      act_sel_r <= SYSCLK_CTRL_RST[SEL_LSB +: 3];
      act_low_r <= SYSCLK_CTRL_RST[LOW_OSC_BIT];
      sw_cnt_r <= '0;
      div_r <= '0;
      mode_r <= MODE_FAST;
      out_r <= '{hsrc_run: 1'b1, hsrc_freq: FREQ_8MHZ, xtal_run: 1'b0,
                 xtal_drive: DRIVE_LOW_POWER, fast_clk_on: 1'b1,
                 sub_clk_on: 1'b1, slow_rc_on: 1'b1, sys_tick: 1'b0,
                 cpu_run: 1'b1};
    end else begin
      sel_r <= sel_nxt;
      low_osc_r <= low_osc_nxt;
      fast_keep_r <= fast_keep_nxt;
      slow_keep_r <= slow_keep_nxt;
      hfreq_r <= hfreq_nxt;
      hflag_r <= hflag_nxt;
      hen_r <= hen_nxt;
      drive_r <= drive_nxt;
      xflag_r <= xflag_nxt;
      xen_r <= xen_nxt;
      hcnt_r <= hcnt_nxt;
      xcnt_r <= xcnt_nxt;
      freq_out_r <= freq_out_nxt;
      rdata_r <= rdata_nxt;
      wait_r <= wait_nxt;
      act_sel_r <= act_sel_nxt;
      act_low_r <= act_low_nxt;
      sw_cnt_r <= sw_cnt_nxt;
      div_r <= div_nxt;
      mode_r <= mode_nxt;
      out_r <= out_nxt;
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign clk_out = out_r;
  assign op_mode = mode_r;

endmodule : scm_top

// file: tb/scm_osc_model.sv
// Oscillator tick model at the far side of the clock outputs
`timescale 1ns/10ps
module scm_osc_model
  import scm_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire scm_clk_out_t clk_out,
  output scm_osc_in_t osc_in
);
  logic [2:0] cnt_r;
  logic odd_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
      odd_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 3'h6) ? 3'h0 : cnt_r + 3'h1;
      odd_r <= odd_r ^ (cnt_r == 3'h6);
    end
  end
  assign osc_in.fast_tick = clk_out.hsrc_run & cnt_r[0];
  assign osc_in.slow_rc_tick = (cnt_r == 3'h6);
  assign osc_in.xtal_tick = clk_out.xtal_run & odd_r & (cnt_r == 3'h3);
endmodule : scm_osc_model

// file: tb/scm_properties.sv
// Port checker of the clock and mode control
`timescale 1ns/10ps
module scm_properties
  import scm_pkg::*;
#(
  parameter int HSRC_STAB_TICKS = 64,
  parameter int XTAL_STAB_TICKS = 256
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic halt_req,
  input wire logic wake_req,
  input wire scm_osc_in_t osc_in,
  input wire scm_clk_out_t clk_out,
  input wire scm_mode_t op_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ****************************************
  // Assertions
  // ****************************************
  AST_SLOW_RC_ON: assert property (clk_out.slow_rc_on)
    else $error("slow rc clock stopped");
  AST_SLEEP: assert property (op_mode == MODE_SLEEP |->
    !(clk_out.fast_clk_on | clk_out.sub_clk_on | clk_out.sys_tick))
    else $error("clock running in sleep");
  AST_IDLE_SUB: assert property (op_mode == MODE_IDLE_SUB_ONLY |->
    !clk_out.fast_clk_on && clk_out.sub_clk_on) else $error("idle sub");
  AST_IDLE_BOTH: assert property (op_mode == MODE_IDLE_BOTH_CLOCKS |->
    clk_out.fast_clk_on && clk_out.sub_clk_on) else $error("idle both");
  AST_IDLE_FAST: assert property (op_mode == MODE_IDLE_FAST_ONLY |->
    clk_out.fast_clk_on && !clk_out.sub_clk_on) else $error("idle fast");
  AST_FAST: assert property (op_mode == MODE_FAST |->
    clk_out.fast_clk_on && clk_out.sub_clk_on) else $error("fast mode");
  AST_HALT: assert property (halt_req && clk_out.cpu_run |=>
    !clk_out.cpu_run [*2]) else $error("halt not taken");
  AST_WAKE: assert property (wake_req && !clk_out.cpu_run |=>
    clk_out.cpu_run) else $error("wake not taken");
  COV_SLEEP: cover property (op_mode == MODE_SLEEP);
  COV_IDLE: cover property (op_mode == MODE_IDLE_BOTH_CLOCKS);
  COV_WAKE: cover property ($rose(clk_out.cpu_run));
endmodule : scm_properties
bind scm_top scm_properties #(
  .HSRC_STAB_TICKS(HSRC_STAB_TICKS), .XTAL_STAB_TICKS(XTAL_STAB_TICKS)
) i_props (
  .clock(clock), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .halt_req(halt_req),
  .wake_req(wake_req), .osc_in(osc_in), .clk_out(clk_out),
  .op_mode(op_mode)
);

// file: tb/testbench.sv
// Self-checking bench of the clock and mode control
`timescale 1ns/10ps
module testbench
  import scm_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic halt_req = 1'b0;
  logic wake_req = 1'b0;
  scm_osc_in_t osc_in;
  scm_clk_out_t clk_out;
  scm_mode_t op_mode;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  logic [31:0] seed = 32'h0000001E;
  logic [31:0] q;
  logic [2:0] s;
  logic [1:0] d;
  always #5 clock = ~clock;
  scm_top #(.HSRC_STAB_TICKS(4), .XTAL_STAB_TICKS(4)) i_dut (
    .clock(clock), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halt_req(halt_req),
    .wake_req(wake_req), .osc_in(osc_in), .clk_out(clk_out),
    .op_mode(op_mode));
  scm_osc_model i_osc (.clock(clock), .rstn(rstn), .clk_out(clk_out),
    .osc_in(osc_in));
  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic give_up();
    error_cnt++;
    $display("Error at %0t: wait timed out", $time);
    end_of_test();
  endtask : give_up
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic scm_mode_t halt_mode(input logic [1:0] k);
    case (k)
      2'h0: return MODE_SLEEP;
      2'h1: return MODE_IDLE_SUB_ONLY;
      2'h2: return MODE_IDLE_FAST_ONLY;
      default: return MODE_IDLE_BOTH_CLOCKS;
    endcase
  endfunction : halt_mode
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h000000, v};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    if (k >= 40) give_up();
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    repeat (2) @(negedge clock);
  endtask : bus
  task automatic wait_flag(input logic [3:0] a);
    int k;
    for (k = 0; k < 40 && q[FLAG_BIT] !== 1'b1; k++) bus(1'b0, a, 8'h00);
    if (k >= 40) give_up();
  endtask : wait_flag
  task automatic wait_mode(input scm_mode_t m);
    int k;
    for (k = 0; k < 1000 && op_mode !== m; k++) @(negedge clock);
    if (k >= 1000) give_up();
    check(op_mode, m);
  endtask : wait_mode
  task automatic halt_wake(input logic h);
    @(posedge clock);
    halt_req <= h;
    wake_req <= ~h;
    @(posedge clock);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
  endtask : halt_wake
  task automatic cnt_ticks();
    n = 0;
    repeat (448) begin
      @(negedge clock);
      n += clk_out.sys_tick;
    end
  endtask : cnt_ticks
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    bus(1'b0, ADDR_FAST_RC_CTRL, 8'h00);
    check(q, {24'h0, FAST_RC_CTRL_RST});
    bus(1'b0, ADDR_XTAL_CTRL, 8'h00);
    check(q, {24'h0, XTAL_CTRL_RST});
    bus(1'b1, 4'hC, 8'hFF);
    bus(1'b0, ADDR_SYSCLK_CTRL, 8'h00);
    check(q, {24'h0, SYSCLK_CTRL_RST});
    bus(1'b0, 4'hC, 8'h00);
    check(q, 32'h0);
    d = FREQ_8MHZ;
    for (int c = 1; c < 5; c++) begin
      bus(1'b1, ADDR_FAST_RC_CTRL, {4'h0, c[1:0], 2'h1});
      check(clk_out.hsrc_freq, d);
      bus(1'b0, ADDR_FAST_RC_CTRL, 8'h00);
      check(q[FLAG_BIT], 1'b0);
      wait_flag(ADDR_FAST_RC_CTRL);
      d = (c[1:0] == 2'h3) ? FREQ_8MHZ : c[1:0];
      check(clk_out.hsrc_freq, d);
    end
    void'(rnd());
    d = seed[1:0];
    bus(1'b1, ADDR_XTAL_CTRL, {4'h0, d, 2'h1});
    bus(1'b0, ADDR_XTAL_CTRL, 8'h00);
    check(q[FLAG_BIT], 1'b0);
    wait_flag(ADDR_XTAL_CTRL);
    check(clk_out.xtal_drive, d);
    check(clk_out.xtal_run, 1'b1);
    bus(1'b1, ADDR_SYSCLK_CTRL, 8'hE4);
    wait_mode(MODE_SLOW);
    cnt_ticks();
    check(n >= 31 && n <= 33, 1'b1);
    bus(1'b1, ADDR_XTAL_CTRL, {4'h0, ~d, 2'h1});
    check(clk_out.xtal_drive, d);
    bus(1'b1, ADDR_FAST_RC_CTRL, 8'h00);
    check(clk_out.hsrc_run, 1'b0);
    check(clk_out.fast_clk_on, 1'b0);
    bus(1'b1, ADDR_FAST_RC_CTRL, 8'h01);
    wait_flag(ADDR_FAST_RC_CTRL);
    bus(1'b1, ADDR_SYSCLK_CTRL, 8'hE0);
    repeat (100) @(negedge clock);
    cnt_ticks();
    check(n >= 63 && n <= 65, 1'b1);
    for (int c = 0; c < 7; c++) begin
      bus(1'b1, ADDR_SYSCLK_CTRL, {c[2:0], 5'h00});
      repeat (600) @(negedge clock);
      cnt_ticks();
      check(n >= (192 >> c) - 1 && n <= (192 >> c) + 1, 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      void'(rnd());
      s = seed[2:0];
      bus(1'b1, ADDR_SYSCLK_CTRL, {s, 3'h0, k[1:0]});
      repeat (700) @(negedge clock);
      halt_wake(1'b1);
      wait_mode(halt_mode(k[1:0]));
      check(clk_out.fast_clk_on, k[1]);
      check(clk_out.sub_clk_on, k[0]);
      halt_wake(1'b0);
      wait_mode((s == SEL_SUB) ? MODE_SLOW : MODE_FAST);
    end
    end_of_test();
  end
endmodule : testbench
